// File: hw/ipr_pkg.sv
// Package: register map, field layout and reset values of the priority block
package ipr_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFF_ADC_UART = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_PIN_I2C = 4'h4;
   localparam int PRIO_W = 3;
   localparam int REG_W = 16;
   localparam int LVL_W = 3;
   // Field low-bit positions
   localparam int POS_ADC = 4;
   localparam int POS_UART_TX = 0;
   localparam int POS_PIN_CHANGE = 12;
   localparam int POS_I2C_MASTER = 4;
   localparam int POS_I2C_SLAVE = 0;
   localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
   localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
   localparam logic [PRIO_W-1:0] PRIO_TOP = 3'h7;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

// File: hw/ipr_prio_field.sv
// One read/write priority field with its enable and level decode
`timescale 1ns/1ps
module ipr_prio_field
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic wrEn,
   input wire logic [ipr_pkg::PRIO_W-1:0] wrData,
   output logic [ipr_pkg::PRIO_W-1:0] prio,
   output logic srcEnabled,
   output logic [ipr_pkg::LVL_W-1:0] level
);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         prio <= ipr_pkg::PRIO_RESET;
      else if (ce && wrEn)
         prio <= wrData;
   end

   // Code 000 masks the source; other codes are their own level
   assign srcEnabled = (prio != ipr_pkg::PRIO_OFF);
   assign level = prio;

   ////////////////////////////////////////////////////////////////////////////
   field_off_a: assert property (@(posedge clk) disable iff (rst)
      (prio == ipr_pkg::PRIO_OFF) |-> !srcEnabled) else $error("zero code not disabled");
   field_lvl_a: assert property (@(posedge clk) disable iff (rst)
      srcEnabled |-> (level == prio && level != ipr_pkg::PRIO_OFF)) else $error("level mismatch");
   field_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrEn) |=> (prio == $past(wrData))) else $error("field write lost");
   field_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(ce && wrEn) |=> $stable(prio)) else $error("field changed unwritten");
endmodule

// File: hw/ipr_priority_regs.sv
// Top: AHB-Lite slave holding the two priority control registers
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module ipr_priority_regs
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic [4:0] srcEnabled,
   output logic [14:0] srcLevel
);
   ////////////////////////////////////////////////////////////////////////////
   // Address phase capture
   logic wrPend;
   logic [ipr_pkg::ADDR_W-1:0] wrAddr;
   logic accept;
   logic [4:0] fieldWr;
   logic [ipr_pkg::PRIO_W-1:0] adcDonePriority;
   logic [ipr_pkg::PRIO_W-1:0] uartTxPriority;
   logic [ipr_pkg::PRIO_W-1:0] pinChangePriority;
   logic [ipr_pkg::PRIO_W-1:0] i2cMasterEventPriority;
   logic [ipr_pkg::PRIO_W-1:0] i2cSlaveEventPriority;
   logic [ipr_pkg::REG_W-1:0] regAdcUart;
   logic [ipr_pkg::REG_W-1:0] regPinI2c;
   logic [ipr_pkg::REG_W-1:0] next_rdata;
   logic [ipr_pkg::PRIO_W-1:0] fieldData [5];

   assign accept = ce && hsel && hready && htrans == ipr_pkg::HTRANS_NONSEQ;
   // Zero-wait and OKAY while enabled; a low ce stalls the bus so no transfer is lost
   assign hreadyout = ce;
   assign hresp = 1'b0;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend <= 1'b0;
         wrAddr <= '0;
      end
      else if (ce)
      begin
         wrPend <= accept && hwrite;
         wrAddr <= haddr[ipr_pkg::ADDR_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register images; only field bits are stored, the rest are constant zero
   always_comb
   begin
      regAdcUart = '0;
      regAdcUart[ipr_pkg::POS_ADC +: ipr_pkg::PRIO_W] = adcDonePriority;
      regAdcUart[ipr_pkg::POS_UART_TX +: ipr_pkg::PRIO_W] = uartTxPriority;
      regPinI2c = '0;
      regPinI2c[ipr_pkg::POS_PIN_CHANGE +: ipr_pkg::PRIO_W] = pinChangePriority;
      regPinI2c[ipr_pkg::POS_I2C_MASTER +: ipr_pkg::PRIO_W] = i2cMasterEventPriority;
      regPinI2c[ipr_pkg::POS_I2C_SLAVE +: ipr_pkg::PRIO_W] = i2cSlaveEventPriority;
   end

   always_comb
   begin
      fieldWr = '0;
      if (wrPend && wrAddr == ipr_pkg::OFF_ADC_UART)
         fieldWr[1:0] = 2'h3;
      if (wrPend && wrAddr == ipr_pkg::OFF_PIN_I2C)
         fieldWr[4:2] = 3'h7;
   end

   assign fieldData[0] = hwdata[ipr_pkg::POS_ADC +: ipr_pkg::PRIO_W];
   assign fieldData[1] = hwdata[ipr_pkg::POS_UART_TX +: ipr_pkg::PRIO_W];
   assign fieldData[2] = hwdata[ipr_pkg::POS_PIN_CHANGE +: ipr_pkg::PRIO_W];
   assign fieldData[3] = hwdata[ipr_pkg::POS_I2C_MASTER +: ipr_pkg::PRIO_W];
   assign fieldData[4] = hwdata[ipr_pkg::POS_I2C_SLAVE +: ipr_pkg::PRIO_W];

   // One field per source: slot i of srcEnabled and srcLevel belongs to source i
   ipr_prio_field i_ipr_prio_field_adc
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(fieldWr[0]),
      .wrData(fieldData[0]),
      .prio(adcDonePriority),
      .srcEnabled(srcEnabled[0]),
      .level(srcLevel[0 +: ipr_pkg::LVL_W])
   );

   ipr_prio_field i_ipr_prio_field_uart_tx
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(fieldWr[1]),
      .wrData(fieldData[1]),
      .prio(uartTxPriority),
      .srcEnabled(srcEnabled[1]),
      .level(srcLevel[ipr_pkg::LVL_W +: ipr_pkg::LVL_W])
   );

   ipr_prio_field i_ipr_prio_field_pin_change
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(fieldWr[2]),
      .wrData(fieldData[2]),
      .prio(pinChangePriority),
      .srcEnabled(srcEnabled[2]),
      .level(srcLevel[2*ipr_pkg::LVL_W +: ipr_pkg::LVL_W])
   );

   ipr_prio_field i_ipr_prio_field_i2c_master
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(fieldWr[3]),
      .wrData(fieldData[3]),
      .prio(i2cMasterEventPriority),
      .srcEnabled(srcEnabled[3]),
      .level(srcLevel[3*ipr_pkg::LVL_W +: ipr_pkg::LVL_W])
   );

   ipr_prio_field i_ipr_prio_field_i2c_slave
   (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .wrEn(fieldWr[4]),
      .wrData(fieldData[4]),
      .prio(i2cSlaveEventPriority),
      .srcEnabled(srcEnabled[4]),
      .level(srcLevel[4*ipr_pkg::LVL_W +: ipr_pkg::LVL_W])
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read data registered at the end of the address phase; unmapped offsets read zero
   always_comb
   begin
      next_rdata = '0;
      if (haddr[ipr_pkg::ADDR_W-1:0] == ipr_pkg::OFF_ADC_UART)
         next_rdata = regAdcUart;
      else if (haddr[ipr_pkg::ADDR_W-1:0] == ipr_pkg::OFF_PIN_I2C)
         next_rdata = regPinI2c;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         hrdata <= '0;
      else if (ce && accept && !hwrite)
         hrdata <= {16'h0, next_rdata};
   end

   ////////////////////////////////////////////////////////////////////////////
   reset_value_a: assert property (@(posedge clk) $fell(rst) |->
      (regPinI2c == 16'h4044 && regAdcUart == 16'h0044)) else $error("bad reset");
   unimpl_zero_a: assert property (@(posedge clk) disable iff (rst)
      (regPinI2c & 16'h8f88) == 16'h0 && (regAdcUart & 16'hff88) == 16'h0)
      else $error("unimpl bit");
   upper_zero_a: assert property (@(posedge clk) disable iff (rst)
      hrdata[31:16] == 16'h0) else $error("upper read bits set");
   adc_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrPend && wrAddr == ipr_pkg::OFF_ADC_UART) |=>
      regAdcUart[6:4] == $past(hwdata[6:4])) else $error("adc field write");
   uart_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrPend && wrAddr == ipr_pkg::OFF_ADC_UART) |=>
      regAdcUart[2:0] == $past(hwdata[2:0])) else $error("uart field write");
   pin_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrPend && wrAddr == ipr_pkg::OFF_PIN_I2C) |=>
      regPinI2c[14:12] == $past(hwdata[14:12])) else $error("pin field write");
   master_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrPend && wrAddr == ipr_pkg::OFF_PIN_I2C) |=>
      regPinI2c[6:4] == $past(hwdata[6:4])) else $error("master field write");
   slave_wr_a: assert property (@(posedge clk) disable iff (rst)
      (ce && wrPend && wrAddr == ipr_pkg::OFF_PIN_I2C) |=>
      regPinI2c[2:0] == $past(hwdata[2:0])) else $error("slave field write");
   adc_read_a: assert property (@(posedge clk) disable iff (rst)
      (ce && accept && !hwrite && haddr[3:0] == ipr_pkg::OFF_ADC_UART && !wrPend) |=>
      hrdata[15:0] == $past(regAdcUart)) else $error("readback reg0 wrong");
   read_back_a: assert property (@(posedge clk) disable iff (rst)
      (ce && accept && !hwrite && haddr[3:0] == ipr_pkg::OFF_PIN_I2C && !wrPend) |=>
      hrdata[15:0] == $past(regPinI2c)) else $error("readback wrong");
   top_level_a: assert property (@(posedge clk) disable iff (rst)
      (i2cMasterEventPriority == ipr_pkg::PRIO_TOP) |-> srcLevel[11:9] == 3'h7)
      else $error("code 7 level");
   off_src_a: assert property (@(posedge clk) disable iff (rst)
      (adcDonePriority == ipr_pkg::PRIO_OFF) |-> !srcEnabled[0]) else $error("off enabled");
   src_enable_a: assert property (@(posedge clk) disable iff (rst)
      srcEnabled == {i2cSlaveEventPriority != ipr_pkg::PRIO_OFF,
      i2cMasterEventPriority != ipr_pkg::PRIO_OFF, pinChangePriority != ipr_pkg::PRIO_OFF,
      uartTxPriority != ipr_pkg::PRIO_OFF, adcDonePriority != ipr_pkg::PRIO_OFF})
      else $error("source enable wrong");
   low_level_a: assert property (@(posedge clk) disable iff (rst)
      (pinChangePriority == 3'h1) |-> (srcLevel[8:6] == 3'h1 && srcEnabled[2]))
      else $error("code 1 level");
   stall_ready_a: assert property (@(posedge clk) disable iff (rst)
      hreadyout == ce) else $error("ready not following ce");
   stall_hold_a: assert property (@(posedge clk) disable iff (rst)
      !ce |=> ($stable(regAdcUart) && $stable(regPinI2c) && $stable(hrdata)))
      else $error("state moved while stalled");
   rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
      !(ce && accept && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
   cov_write_c: cover property (@(posedge clk) ce && wrPend);
   cov_read_c: cover property (@(posedge clk) ce && accept && !hwrite);
   cov_off_c: cover property (@(posedge clk) srcEnabled == 5'h0);
   cov_stall_c: cover property (@(posedge clk) !ce && hsel && htrans == ipr_pkg::HTRANS_NONSEQ);
   cov_top_c: cover property (@(posedge clk) srcLevel == {5{ipr_pkg::PRIO_TOP}});
endmodule

// File: testbench/ipr_priority_regs_test.sv
// Testbench for the priority register block over AHB-Lite
`timescale 1ns/1ps
module ipr_priority_regs_test;
   localparam logic [31:0] A0 = {28'h0, ipr_pkg::OFF_ADC_UART};
   localparam logic [31:0] A1 = {28'h0, ipr_pkg::OFF_PIN_I2C};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = ipr_pkg::HSIZE_WORD;
   logic hready, hreadyout, hresp;
   logic [31:0] hrdata;
   logic [4:0] srcEnabled;
   logic [14:0] srcLevel;
   int fail_count = 0;
   int checks = 0;
   ////////////////////////////////////////////////////////////////////////////////
   always #25 clk = ~clk;
   // Single slave, so its hreadyout is the bus hready
   assign hready = hreadyout;
   ipr_priority_regs i_ipr_priority_regs (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .srcEnabled(srcEnabled), .srcLevel(srcLevel));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge clk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 50)
         begin
            fail_count++;
            $display("unexpected hreadyout expected 1 seen %b", hreadyout);
            end_of_test();
         end
         @(posedge clk);
      end
   endtask
   // Leading idle cycle so a read never meets the write just before it
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= ipr_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      logic [31:0] q;
      chk("hrdata reset", 32'h0, hrdata);
      bus(1'b0, A0, 32'h0, q);
      chk("reg0 reset", 32'h0044, q);
      bus(1'b0, A1, 32'h0, q);
      chk("reg1 reset", 32'h4044, q);
      chk("srcLevel reset", {17'h0, {5{3'h4}}}, {17'h0, srcLevel});
      chk("srcEnabled reset", 32'h1f, {27'h0, srcEnabled});
      $display("test_reset done");
   endtask
   task automatic test_codes;
      logic [31:0] q;
      logic [2:0] c;
      for (int i = 0; i < 8; i++)
      begin
         c = 3'(i);
         bus(1'b1, A0, {25'h0, c, 1'b0, c}, q);
         bus(1'b1, A1, {17'h0, c, 5'h0, c, 1'b0, c}, q);
         bus(1'b0, A0, 32'h0, q);
         chk("reg0 code", {25'h0, c, 1'b0, c}, q);
         bus(1'b0, A1, 32'h0, q);
         chk("reg1 code", {17'h0, c, 5'h0, c, 1'b0, c}, q);
         chk("srcLevel code", {17'h0, {5{c}}}, {17'h0, srcLevel});
         chk("srcEnabled code", {27'h0, {5{c != 3'h0}}}, {27'h0, srcEnabled});
      end
      $display("test_codes done");
   endtask
   // Distinct values per field catch swapped or shifted fields
   task automatic test_unimpl;
      logic [31:0] q;
      bus(1'b1, A0, 32'hffff_ff52, q);
      bus(1'b1, A1, 32'hffff_ef9f, q);
      bus(1'b1, 32'h8, 32'hffff_ffff, q);
      bus(1'b0, A0, 32'h0, q);
      chk("reg0 unimpl", 32'h0052, q);
      bus(1'b0, A1, 32'h0, q);
      chk("reg1 unimpl", 32'h6017, q);
      bus(1'b0, 32'h8, 32'h0, q);
      chk("unmapped read", 32'h0, q);
      chk("srcLevel fields", {17'h0, 3'h7, 3'h1, 3'h6, 3'h2, 3'h5}, {17'h0, srcLevel});
      $display("test_unimpl done");
   endtask
   // A write issued while ce is low must wait, then land once ce returns
   task automatic test_ce;
      logic [31:0] q;
      @(posedge clk);
      ce <= 1'b0;
      @(posedge clk);
      chk("hreadyout stall", 32'h0, {31'h0, hreadyout});
      fork
         bus(1'b1, A0, 32'h0000_0031, q);
         begin
            repeat (4) @(posedge clk);
            ce <= 1'b1;
         end
      join
      bus(1'b0, A0, 32'h0, q);
      chk("reg0 after stall", 32'h0031, q);
      chk("srcLevel after stall", {17'h0, 3'h7, 3'h1, 3'h6, 3'h1, 3'h3}, {17'h0, srcLevel});
      $display("test_ce done");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_codes();
      test_unimpl();
      test_ce();
      end_of_test();
   end
endmodule
